// file: hub_net_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// hubs and amplifiers on the far side of both lines
// ==========================================================================
module hub_net_model
    import hub_pkg::*;
(
    // clock
    input wire logic mclk,
    // layout asked for by the bench
    input wire logic [NUM_LINES-1:0][NUM_HUBS-1:0] amp_plan,
    input wire logic [NUM_LINES-1:0][NUM_HUBS-1:0] fault_plan,
    input wire axis_cfg_t [NUM_LINES-1:0][NUM_AXES-1:0] axis_plan,
    // toward the block
    output logic [NUM_LINES-1:0][NUM_HUBS-1:0] amp_attached,
    output logic [NUM_LINES-1:0][NUM_HUBS-1:0] hub_err_evt,
    output axis_cfg_t [NUM_LINES-1:0][NUM_AXES-1:0] axis_cfg
);
    // attachments, fault pulses and axis placement one cycle after the plan
    always_ff @(posedge mclk) begin
        amp_attached <= amp_plan;
        hub_err_evt <= fault_plan;
        axis_cfg <= axis_plan;
    end
endmodule

`default_nettype wire

// file: hub_route_check.sv
// ==========================================================================
// shared constants and types
// ==========================================================================
package hub_pkg;

    // sizes
    localparam int NUM_LINES = 2;
    localparam int NUM_HUBS = 16;
    localparam int NUM_AXES = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int AXIS_IDX_W = 4;
    localparam int HUB_IDX_W = 4;
    localparam int PORT_W = 2;

    // register byte offsets
    localparam logic [7:0] ADDR_INST_L1 = 8'h00;
    localparam logic [7:0] ADDR_INST_L2 = 8'h04;
    localparam logic [7:0] ADDR_ERR_L1 = 8'h08;
    localparam logic [7:0] ADDR_ERR_L2 = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_DC_EN_L1 = 8'h18;
    localparam logic [7:0] ADDR_DC_EN_L2 = 8'h1c;
    localparam logic [7:0] ADDR_STOP = 8'h20;

    // interrupt status layout
    localparam int IRQ_W = 4;
    localparam int IRQ_ERR_BASE = 0;
    localparam int IRQ_STOP_BASE = 2;

    // reset values
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // main-route amps ahead of the first hub carry this hub count
    localparam logic [HUB_IDX_W-1:0] FIRST_HUB = 4'h0;

    // where an amplifier sits on a line
    typedef struct packed {
        logic on_sub;                 // 1: branch route, 0: main route
        logic [HUB_IDX_W-1:0] hub;    // main: hubs passed, sub: hub it hangs off
        logic [PORT_W-1:0] port;      // branch port on that hub
    } axis_pos_t;

    // per-axis driver communication setup
    typedef struct packed {
        logic confirmed;              // connection seen by the controller
        logic [AXIS_IDX_W-1:0] partner;
        axis_pos_t pos;
    } axis_cfg_t;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// route check for one pair of amplifiers
// ==========================================================================
module hub_route_check
    import hub_pkg::*;
(
    // the two ends
    input wire axis_pos_t a,
    input wire axis_pos_t b,
    // verdict
    output logic ok
);

    wire both_main = !a.on_sub && !b.on_sub;
    wire both_sub = a.on_sub && b.on_sub;
    wire same_branch = (a.hub == b.hub) && (a.port == b.port);
    wire a_main_first = !a.on_sub && (a.hub == FIRST_HUB);
    wire b_main_first = !b.on_sub && (b.hub == FIRST_HUB);
    wire a_sub_first = a.on_sub && (a.hub == FIRST_HUB);
    wire b_sub_first = b.on_sub && (b.hub == FIRST_HUB);

    // allowed routes only
    assign ok = both_main
        || (both_sub && same_branch)
        || (a_main_first && b_sub_first)
        || (b_main_first && a_sub_first);

endmodule

`default_nettype wire

// file: hub_status_routing.sv
`timescale 1ns/1ps
`default_nettype none

module hub_status_routing
    import hub_pkg::*;
#(
    parameter int LINES = NUM_LINES,
    parameter int HUBS = NUM_HUBS,
    parameter int AXES = NUM_AXES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire reg_req_t req,
    output logic [DATA_W-1:0] rdata,
    // operation cycle strobe
    input wire logic op_cycle,
    // hub reports, per line
    input wire logic [LINES-1:0][HUBS-1:0] amp_attached,
    input wire logic [LINES-1:0][HUBS-1:0] hub_err_evt,
    // axis placement, per line
    input wire axis_cfg_t [LINES-1:0][AXES-1:0] axis_cfg,
    // link stop, per line
    output logic [LINES-1:0] line_stop,
    // interrupt
    output logic irq
);

    // keeps what software reads about the hubs of both lines
    // and watches the driver communication setup of every axis;
    // no waits on the register port and no buffering anywhere

    // ======================================================================
    // state
    // ======================================================================

    // every register below gets its _next value from the logic further down

    // installed words, one per line
    logic [LINES-1:0][HUBS-1:0] inst_reg;
    logic [LINES-1:0][HUBS-1:0] inst_next;

    // sticky hub error words, one per line
    logic [LINES-1:0][HUBS-1:0] err_reg;
    logic [LINES-1:0][HUBS-1:0] err_next;

    // driver communication enables, one bit per axis
    logic [LINES-1:0][AXES-1:0] dc_en_reg;
    logic [LINES-1:0][AXES-1:0] dc_en_next;

    // line stop, one bit per line
    logic [LINES-1:0] stop_reg;
    logic [LINES-1:0] stop_next;

    // interrupt status and mask
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] stat_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] mask_next;

    // interrupt level
    logic irq_reg;
    logic irq_next;

    // read answer
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // ======================================================================
    // address decode
    // ======================================================================

    // installed words and the stop word have no write decode:
    // writes to them fall through and change nothing

    // interrupt register writes
    wire wr_stat = req.wr && (req.addr == ADDR_IRQ_STAT);
    wire wr_mask = req.wr && (req.addr == ADDR_IRQ_MASK);
    wire [LINES-1:0] wr_err;
    wire [LINES-1:0] wr_dc;

    // write data cut to each register's width
    wire [HUBS-1:0] wdata_hubs = req.wdata[HUBS-1:0];
    wire [AXES-1:0] wdata_axes = req.wdata[AXES-1:0];
    wire [IRQ_W-1:0] wdata_irq = req.wdata[IRQ_W-1:0];

    // error word clears, one per line
    assign wr_err[0] = req.wr && (req.addr == ADDR_ERR_L1);
    assign wr_err[1] = req.wr && (req.addr == ADDR_ERR_L2);

    // driver communication enables, one per line
    assign wr_dc[0] = req.wr && (req.addr == ADDR_DC_EN_L1);
    assign wr_dc[1] = req.wr && (req.addr == ADDR_DC_EN_L2);

    // ======================================================================
    // per line logic
    // ======================================================================

    // installed bit: an or-chain from the far end of the line back
    // towards the controller, so a hub reads installed whenever any
    // hub further out still carries an amplifier
    //
    // error flags: set by the hub report, kept through hub power
    // cycles and reconnects, dropped only by a write of ones or reset
    //
    // route check: each enabled axis is tried against its partner; one
    // bad pair stops the whole line, axes without driver communication too

    wire [LINES-1:0] err_any;
    wire [LINES-1:0] stop_rise;

    genvar l;
    genvar h;
    genvar x;
    generate
        for (l = 0; l < LINES; l = l + 1) begin : g_line
            // installed: hub holds an amp or lies upstream of one
            // the chain runs from the last hub back to the first
            wire [HUBS-1:0] reach;
            assign reach[HUBS-1] = amp_attached[l][HUBS-1];
            for (h = 0; h < HUBS - 1; h = h + 1) begin : g_hub
                assign reach[h] = amp_attached[l][h] || reach[h+1];
            end

            // refresh only on the operation cycle; trailing empty hubs read 0
            assign inst_next[l] = op_cycle ? reach : inst_reg[l];

            // sticky flags, set wins over software clear
            wire [HUBS-1:0] clr = wr_err[l] ? wdata_hubs : '0;
            // flags not cleared by this write
            wire [HUBS-1:0] keep = err_reg[l] & ~clr;
            assign err_next[l] = keep | hub_err_evt[l];
            assign err_any[l] = |hub_err_evt[l];

            // driver communication enable per axis
            assign dc_en_next[l] = wr_dc[l] ? wdata_axes : dc_en_reg[l];

            // one route check per axis against its partner
            // the partner index picks the other end of the pair; an axis
            // paired with itself is one route and always passes the route check
            // refused: two different branches, or a main axis paired with a
            // branch axis unless both sit at the first hub
            wire [AXES-1:0] bad;
            for (x = 0; x < AXES; x = x + 1) begin : g_axis
                wire pair_ok;
                axis_cfg_t me;
                axis_cfg_t other;
                assign me = axis_cfg[l][x];
                assign other = axis_cfg[l][me.partner];
                hub_route_check u_chk (
                    .a(me.pos),
                    .b(other.pos),
                    .ok(pair_ok)
                );
                // route between the two ends not allowed
                wire place_bad = !pair_ok;
                // either end not yet seen by the controller
                wire link_bad = !me.confirmed || !other.confirmed;
                // only axes set for driver communication count
                assign bad[x] = dc_en_reg[l][x] && (place_bad || link_bad);
            end

            // whole line stops, all axes included
            // a stopped line resumes by itself once the setup is mended
            assign stop_next[l] = |bad;
            assign stop_rise[l] = stop_next[l] && !stop_reg[l];
        end
    endgenerate

    // ======================================================================
    // interrupt status and mask
    // ======================================================================
    wire [IRQ_W-1:0] irq_evt;
    wire [IRQ_W-1:0] stat_clr = wr_stat ? wdata_irq : '0;

    // per line events into the status word
    // bits: line errors from the bottom, then line stops
    genvar n;
    generate
        for (n = 0; n < LINES; n = n + 1) begin : g_evt
            // a hub error seen on the line
            assign irq_evt[IRQ_ERR_BASE + n] = err_any[n];
            // the line has just been stopped
            assign irq_evt[IRQ_STOP_BASE + n] = stop_rise[n];
        end
    endgenerate

    // status bits are sticky; an event in the same cycle as a write-one
    // clear wins, so a clear racing with it cannot lose the event
    // set wins over write-one-to-clear
    assign stat_next = (stat_reg & ~stat_clr) | irq_evt;
    assign mask_next = wr_mask ? wdata_irq : mask_reg;
    // level follows next status and mask, so it rises with the status bit
    assign irq_next = |(stat_next & mask_next);

    // ======================================================================
    // read mux
    // ======================================================================

    // the answer is registered: it stands one cycle after the strobe
    // and is zero otherwise, so several slaves can share one bus

    // address hits, one per register
    wire hit_inst_l1 = req.addr == ADDR_INST_L1;
    wire hit_inst_l2 = req.addr == ADDR_INST_L2;
    wire hit_err_l1 = req.addr == ADDR_ERR_L1;
    wire hit_err_l2 = req.addr == ADDR_ERR_L2;
    wire hit_stat = req.addr == ADDR_IRQ_STAT;
    wire hit_mask = req.addr == ADDR_IRQ_MASK;
    wire hit_dc_l1 = req.addr == ADDR_DC_EN_L1;
    wire hit_dc_l2 = req.addr == ADDR_DC_EN_L2;
    wire hit_stop = req.addr == ADDR_STOP;

    // words as they read back, zero above their width
    wire [DATA_W-1:0] word_inst_l1 = DATA_W'(inst_reg[0]);
    wire [DATA_W-1:0] word_inst_l2 = DATA_W'(inst_reg[1]);
    wire [DATA_W-1:0] word_err_l1 = DATA_W'(err_reg[0]);
    wire [DATA_W-1:0] word_err_l2 = DATA_W'(err_reg[1]);
    wire [DATA_W-1:0] word_stat = DATA_W'(stat_reg);
    wire [DATA_W-1:0] word_mask = DATA_W'(mask_reg);
    wire [DATA_W-1:0] word_dc_l1 = DATA_W'(dc_en_reg[0]);
    wire [DATA_W-1:0] word_dc_l2 = DATA_W'(dc_en_reg[1]);
    wire [DATA_W-1:0] word_stop = DATA_W'(stop_reg);

    // one-hot select; an unmapped address hits nothing and reads zero
    wire [DATA_W-1:0] rd_sel = ({DATA_W{hit_inst_l1}} & word_inst_l1)
        | ({DATA_W{hit_inst_l2}} & word_inst_l2)
        | ({DATA_W{hit_err_l1}} & word_err_l1)
        | ({DATA_W{hit_err_l2}} & word_err_l2)
        | ({DATA_W{hit_stat}} & word_stat)
        | ({DATA_W{hit_mask}} & word_mask)
        | ({DATA_W{hit_dc_l1}} & word_dc_l1)
        | ({DATA_W{hit_dc_l2}} & word_dc_l2)
        | ({DATA_W{hit_stop}} & word_stop);

    // answer only after a read strobe, zero otherwise
    assign rdata_next = req.rd ? rd_sel : RDATA_RST;

    // ======================================================================
    // registers
    // ======================================================================

    // synchronous reset clears everything, error flags included;
    // only the hub events themselves are kept from clearing them

    // installed words, refreshed on the operation cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            inst_reg <= '0;
        end else begin
            inst_reg <= inst_next;
        end
    end

    // sticky error words
    always_ff @(posedge mclk) begin
        if (rst) begin
            err_reg <= '0;
        end else begin
            err_reg <= err_next;
        end
    end

    // driver communication enables
    always_ff @(posedge mclk) begin
        if (rst) begin
            dc_en_reg <= '0;
        end else begin
            dc_en_reg <= dc_en_next;
        end
    end

    // line stop
    always_ff @(posedge mclk) begin
        if (rst) begin
            stop_reg <= '0;
        end else begin
            stop_reg <= stop_next;
        end
    end

    // interrupt status
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_reg <= IRQ_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // interrupt mask
    always_ff @(posedge mclk) begin
        if (rst) begin
            mask_reg <= IRQ_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // interrupt level
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // read answer
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================

    // outputs straight from flops
    assign rdata = rdata_reg;
    assign line_stop = stop_reg;
    assign irq = irq_reg;

endmodule

`default_nettype wire

// file: hub_status_routing_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// port checker for the hub status and routing block
// ==========================================================================
module hub_status_routing_chk
    import hub_pkg::*;
#(
    parameter int LINES = NUM_LINES,
    parameter int HUBS = NUM_HUBS,
    parameter int AXES = NUM_AXES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire reg_req_t req,
    input wire logic [DATA_W-1:0] rdata,
    // hub side
    input wire logic op_cycle,
    input wire logic [LINES-1:0][HUBS-1:0] amp_attached,
    input wire logic [LINES-1:0][HUBS-1:0] hub_err_evt,
    input wire axis_cfg_t [LINES-1:0][AXES-1:0] axis_cfg,
    // outputs
    input wire logic [LINES-1:0] line_stop,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // read and write decodes
    wire logic rd_inst = req.rd && !op_cycle && req.addr == ADDR_INST_L1;
    wire logic rd_e1 = req.rd && req.addr == ADDR_ERR_L1;
    wire logic rd_e2 = req.rd && req.addr == ADDR_ERR_L2;
    wire logic rd_word = req.rd && req.addr[7:4] == 4'h0;
    wire logic rd_stop = req.rd && req.addr == ADDR_STOP;
    wire logic wr_e1 = req.wr && req.addr == ADDR_ERR_L1 && req.wdata[3];

    // multi-step stimuli seen at the ports
    sequence fault_l1;
        hub_err_evt[0][3] ##1 rd_e1;
    endsequence
    sequence fault_l2;
        hub_err_evt[1][HUBS-1] ##1 rd_e2;
    endsequence
    sequence refresh_full;
        op_cycle && amp_attached[0][HUBS-1] ##2 rd_inst;
    endsequence
    sequence refresh_none;
        op_cycle && amp_attached[0] == '0 ##2 rd_inst;
    endsequence
    sequence clear_l1;
        wr_e1 && !hub_err_evt[0][3] ##1 !hub_err_evt[0][3] ##1 rd_e1;
    endsequence

    chk_rd_idle: assert property (!$past(req.rd) |-> rdata == '0)
        else $error("read data not zero outside read answer");
    chk_word_upper: assert property (rd_word |=> rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_err_set_l1: assert property (fault_l1 |=> rdata[3])
        else $error("line 1 error flag not set");
    chk_err_set_l2: assert property (fault_l2 |=> rdata[15])
        else $error("line 2 error flag not set");
    chk_inst_full: assert property (refresh_full |=> rdata[15:0] == 16'hffff)
        else $error("hubs before last amplifier not installed");
    chk_inst_none: assert property (refresh_none |=> rdata[15:0] == 16'h0000)
        else $error("empty line shows installed hubs");
    chk_err_clear: assert property (clear_l1 |=> !rdata[3])
        else $error("error flag not cleared by write one");
    chk_stop_read: assert property (rd_stop |=> rdata[31:0] == {30'h0, $past(line_stop)})
        else $error("stop register disagrees with line stop");
endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// self-checking bench
// ==========================================================================
module tb_top
    import hub_pkg::*;
;
    logic mclk;
    logic rst;
    logic op_cycle;
    reg_req_t req;
    logic [DATA_W-1:0] rdata;
    logic [NUM_LINES-1:0][NUM_HUBS-1:0] amp_plan, fault_plan, amp_attached, hub_err_evt;
    axis_cfg_t [NUM_LINES-1:0][NUM_AXES-1:0] axis_plan, axis_cfg;
    logic [NUM_LINES-1:0] line_stop;
    logic irq;
    logic [15:0] row;
    int err_total;
    int cmp_count;
    // attachments and installed words, line 2 gets both shifted right by one
    logic [31:0] inst_rows [5] = '{32'h0000_0000, 32'h0008_000f, 32'h8000_ffff, 32'h0001_0001, 32'h0410_07ff};
    // axis 0 place, axis 1 place, confirmed, line stop expected
    logic [15:0] route_rows [6] = '{{7'h00, 7'h08, 2'b10}, {7'h45, 7'h45, 2'b10}, {7'h00, 7'h41, 2'b10},
                                    {7'h04, 7'h46, 2'b11}, {7'h41, 7'h42, 2'b11}, {7'h00, 7'h0c, 2'b01}};

    hub_status_routing uut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .op_cycle(op_cycle),
        .amp_attached(amp_attached), .hub_err_evt(hub_err_evt), .axis_cfg(axis_cfg),
        .line_stop(line_stop), .irq(irq));
    hub_net_model far_side (.mclk(mclk), .amp_plan(amp_plan), .fault_plan(fault_plan), .axis_plan(axis_plan),
        .amp_attached(amp_attached), .hub_err_evt(hub_err_evt), .axis_cfg(axis_cfg));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    // one-cycle register read, answer checked in the following cycle
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 check(what, rdata, exp);
    endtask

    // operation cycle strobe and hub fault pulse
    task automatic op_pulse;
        @(posedge mclk);
        op_cycle <= 1'b1;
        @(posedge mclk);
        op_cycle <= 1'b0;
    endtask
    task automatic fault(input int l, input logic [15:0] v);
        @(posedge mclk);
        fault_plan[l] <= v;
        @(posedge mclk);
        fault_plan[l] <= 16'h0000;
    endtask

    // settled interrupt level
    task automatic irq_chk(input logic exp);
        @(posedge mclk);
        #1 check("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    // verdict
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (4000) @(posedge mclk);
        err_total++;
        wrap_up();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        op_cycle = 1'b0;
        req = '0;
        amp_plan = '0;
        fault_plan = '0;
        axis_plan = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd_chk("err_l1_rst", ADDR_ERR_L1, 32'h0);
        foreach (inst_rows[i]) begin
            @(posedge mclk);
            amp_plan[0] <= inst_rows[i][31:16];
            amp_plan[1] <= inst_rows[i][31:16] >> 1;
            op_pulse();
            rd_chk("inst_l1", ADDR_INST_L1, {16'h0, inst_rows[i][15:0]});
            rd_chk("inst_l2", ADDR_INST_L2, {16'h0, inst_rows[i][15:0] >> 1});
        end
        wr(ADDR_INST_L1, 32'hffff_0000);
        rd_chk("inst_ro", ADDR_INST_L1, 32'h0000_07ff);
        rd_chk("unmapped", 8'h3c, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h3);
        fault(0, 16'h0008);
        rd_chk("err_l1", ADDR_ERR_L1, 32'h8);
        fault(1, 16'h8000);
        rd_chk("err_l2", ADDR_ERR_L2, 32'h8000);
        irq_chk(1'b1);
        @(posedge mclk);
        amp_plan <= '0;
        op_pulse();
        rd_chk("err_keep", ADDR_ERR_L1, 32'h8);
        wr(ADDR_ERR_L1, 32'h8);
        rd_chk("err_clr", ADDR_ERR_L1, 32'h0);
        rd_chk("err_other", ADDR_ERR_L2, 32'h8000);
        wr(ADDR_IRQ_MASK, 32'h0);
        irq_chk(1'b0);
        wr(ADDR_DC_EN_L1, 32'h3);
        foreach (route_rows[i]) begin
            row = route_rows[i];
            @(posedge mclk);
            axis_plan[0][0] <= axis_cfg_t'{row[1], 4'h1, row[15:9]};
            axis_plan[0][1] <= axis_cfg_t'{row[1], 4'h0, row[8:2]};
            repeat (4) @(posedge mclk);
            rd_chk("stop", ADDR_STOP, {31'h0, row[0]});
            check("line_stop", {31'h0, line_stop[0]}, {31'h0, row[0]});
        end
        wrap_up();
    end
endmodule

bind hub_status_routing hub_status_routing_chk #(.LINES(LINES), .HUBS(HUBS), .AXES(AXES)) chk_i (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .op_cycle(op_cycle), .amp_attached(amp_attached),
    .hub_err_evt(hub_err_evt), .axis_cfg(axis_cfg), .line_stop(line_stop), .irq(irq));

`default_nettype wire
